// ### rtl/rsr_pkg.sv
// Shared constants and types for the rail status register bank
`default_nettype none
package rsr_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int PG_LO_W = 8;
    localparam int PG_HI_W = 6;
    localparam int FLT_LO_W = 8;
    localparam int FLT_HI_W = 5;
    localparam int PG_W = PG_LO_W + PG_HI_W;
    localparam int FLT_W = FLT_LO_W + FLT_HI_W;
    localparam int SYNC_STAGES = 2;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_PG_LO = 8'hb0;
    localparam logic [7:0] IDX_PG_HI = 8'hb1;
    localparam logic [7:0] IDX_FLT_LO = 8'hb2;
    localparam logic [7:0] IDX_FLT_HI = 8'hb3;
    localparam logic [7:0] IDX_MASK_LO = 8'hb8;
    localparam logic [7:0] IDX_MASK_HI = 8'hb9;

    // Field positions
    localparam int BIT_BUCK_1_A = 0;
    localparam int BIT_SWITCHER_A = 6;
    localparam int BIT_AUX_LDO_2 = 7;
    localparam int BIT_AUX_LDO_3 = 0;
    localparam int BIT_SWITCHER_B1 = 1;
    localparam int BIT_SWITCHER_B2 = 2;
    localparam int BIT_DDR_TERMINATION_LDO = 3;
    localparam int BIT_AUX_LDO_1 = 4;
    localparam int BIT_FIXED_5V_LDO = 5;

    // Reset values
    localparam logic [7:0] RST_PG = 8'h00;
    localparam logic [7:0] RST_FLT = 8'h00;
    localparam logic [7:0] RST_MASK = 8'h00;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [PG_HI_W-1:0] hi;
        logic [PG_LO_W-1:0] lo;
    } rsr_pg_t;

    typedef struct packed {
        logic [FLT_HI_W-1:0] hi;
        logic [FLT_LO_W-1:0] lo;
    } rsr_flt_t;
endpackage
`default_nettype wire

// ### rtl/rsr_sync.sv
// Two-stage synchroniser with falling-edge detect per bit
`default_nettype none
module rsr_sync #(
    parameter int W = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] level,
    output logic [W-1:0] fall
);
    import rsr_pkg::*;
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;
    logic [W-1:0] prev_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= '0;
            sync_r <= '0;
            prev_r <= '0;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign level = sync_r;
    assign fall = prev_r & ~sync_r;
endmodule
`default_nettype wire

// ### rtl/rsr_top.sv
// Rail status register bank with AXI4-Lite slave and fault interrupt
//
// Function
// R1: Power-good low register at B0h, read-only
// R2: Power-good bit is 1 while rail regulates
// R3: Power-good high register at B1h, 7:6 reserved
// R4: Power-good registers reset to zero
// R5: Fault low register at B2h, same order
// R6: Regulation loss sets fault; stays set after
// R7: Host clears fault by writing one
// R8: Fault high register at B3h, 7:5 reserved
// R9: Fault flags reset to zero
// R10: Zero writes, read-only, reserved bits ignored
// R11: Set beats simultaneous clear
`default_nettype none
module rsr_top #(
    parameter int ADDR_W = rsr_pkg::ADDR_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire rsr_pkg::rsr_pg_t rail_in_regulation,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [rsr_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [rsr_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);
    import rsr_pkg::*;

    rsr_pg_t pg;
    logic [PG_W-1:0] pg_fall;
    rsr_flt_t fault;
    rsr_flt_t fault_set;
    rsr_flt_t fault_clr;

    logic aw_held_r;
    logic w_held_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [DATA_W-1:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [DATA_W-1:0] rdata_r;
    logic [FLT_LO_W-1:0] mask_lo_r;
    logic [FLT_HI_W-1:0] mask_hi_r;
    logic irq_r;

    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic wr_fire;
    logic wr_lane0;
    logic [7:0] wr_idx;
    logic wr_hit;
    logic [7:0] rd_idx;
    logic rd_hit;
    logic [DATA_W-1:0] rd_data;

    // Rail levels come from the analog side
    rsr_sync #(
        .W(PG_W)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(rail_in_regulation),
        .level(pg), // R2 R4
        .fall(pg_fall)
    );

    // Loss of regulation is a falling power-good level
    always_comb begin
        fault_set.lo = pg_fall[FLT_LO_W-1:0]; // R5 R6
        fault_set.hi = pg_fall[PG_LO_W+FLT_HI_W-1:PG_LO_W]; // R8 R6
    end

    rsr_w1c #(
        .W(FLT_W)
    ) u_fault (
        .aclk(aclk),
        .aresetn(aresetn),
        .set(fault_set),
        .clr(fault_clr),
        .flags(fault) // R9 R11
    );

    // AXI4-Lite channel handshakes
    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready = !w_held_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign aw_hs = s_axi_awvalid && s_axi_awready;
    assign w_hs = s_axi_wvalid && s_axi_wready;
    assign ar_hs = s_axi_arvalid && s_axi_arready;
    assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
    assign wr_lane0 = wr_fire && wstrb_r[0];
    assign wr_idx = awaddr_r[9:2];
    assign rd_idx = s_axi_araddr[9:2];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            awaddr_r <= '0;
        end else if (aw_hs) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r <= 1'b0;
            wdata_r <= '0;
            wstrb_r <= '0;
        end else if (w_hs) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_r <= 1'b0;
        end
    end

    // Address decode; upper bits and byte offset must be zero and the index must be in the map
    always_comb begin
        wr_hit = (awaddr_r[ADDR_W-1:10] == '0) &&
            (awaddr_r[1:0] == 2'h0);
        case (wr_idx)
            IDX_PG_LO, IDX_PG_HI, IDX_FLT_LO, IDX_FLT_HI,
            IDX_MASK_LO, IDX_MASK_HI: begin
            end
            default: begin
                wr_hit = 1'b0;
            end
        endcase
    end

    // Write-one-to-clear on fault flags only
    always_comb begin
        fault_clr = '0;
        if (wr_lane0 && wr_hit && wr_idx == IDX_FLT_LO) begin
            fault_clr.lo = wdata_r[FLT_LO_W-1:0]; // R7 R10
        end
        if (wr_lane0 && wr_hit && wr_idx == IDX_FLT_HI) begin
            fault_clr.hi = wdata_r[FLT_HI_W-1:0]; // R7 R10
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_lo_r <= RST_MASK[FLT_LO_W-1:0];
            mask_hi_r <= RST_MASK[FLT_HI_W-1:0];
        end else if (wr_lane0 && wr_hit) begin
            if (wr_idx == IDX_MASK_LO) begin
                mask_lo_r <= wdata_r[FLT_LO_W-1:0];
            end
            if (wr_idx == IDX_MASK_HI) begin
                mask_hi_r <= wdata_r[FLT_HI_W-1:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    // Read mux; reserved bits read as zero
    always_comb begin
        rd_data = '0;
        rd_hit = (s_axi_araddr[ADDR_W-1:10] == '0) &&
            (s_axi_araddr[1:0] == 2'h0);
        case (rd_idx)
            IDX_PG_LO: begin
                rd_data[PG_LO_W-1:0] = pg.lo; // R1
            end
            IDX_PG_HI: begin
                rd_data[PG_HI_W-1:0] = pg.hi; // R3
            end
            IDX_FLT_LO: begin
                rd_data[FLT_LO_W-1:0] = fault.lo; // R5
            end
            IDX_FLT_HI: begin
                rd_data[FLT_HI_W-1:0] = fault.hi; // R8
            end
            IDX_MASK_LO: begin
                rd_data[FLT_LO_W-1:0] = mask_lo_r;
            end
            IDX_MASK_HI: begin
                rd_data[FLT_HI_W-1:0] = mask_hi_r;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
        if (!rd_hit) begin
            rd_data = '0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= '0;
        end else if (ar_hs) begin
            rvalid_r <= 1'b1;
            rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            rdata_r <= rd_data;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;

    // Level interrupt from fault flags whose mask bit is set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |({mask_hi_r, mask_lo_r} & fault);
        end
    end

    assign irq = irq_r;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_pg_lo_read;
        ar_hs && rd_hit && rd_idx == IDX_PG_LO |=>
            s_axi_rvalid && s_axi_rresp == RESP_OKAY &&
            s_axi_rdata == {24'h0, $past(pg.lo)};
    endproperty
    a_pg_lo_read: assert property (p_pg_lo_read) // R1
        else $error("power-good low read mismatch");

    // Synchroniser refills over two edges after reset
    property p_pg_follows_pin;
        $past(aresetn) && $past(aresetn, 2) |->
            pg == $past(rail_in_regulation, 2);
    endproperty
    a_pg_follows_pin: assert property (p_pg_follows_pin) // R2
        else $error("power-good does not follow rail level");

    property p_pg_hi_read;
        ar_hs && rd_hit && rd_idx == IDX_PG_HI |=>
            s_axi_rdata == {26'h0, $past(pg.hi)};
    endproperty
    a_pg_hi_read: assert property (p_pg_hi_read) // R3
        else $error("power-good high read mismatch");

    property p_pg_reset;
        $past(!aresetn) |-> pg == '0 && fault == '0;
    endproperty
    a_pg_reset: assert property (p_pg_reset) // R4
        else $error("status not zero after reset");

    property p_fault_lo_set;
        pg_fall[FLT_LO_W-1:0] != '0 |=>
            (fault.lo & $past(pg_fall[FLT_LO_W-1:0])) ==
            $past(pg_fall[FLT_LO_W-1:0]);
    endproperty
    a_fault_lo_set: assert property (p_fault_lo_set) // R5
        else $error("fault low flag not set on loss");

    property p_fault_sticky;
        ##1 ($past(fault) & ~$past(fault_clr) & ~fault) == '0;
    endproperty
    a_fault_sticky: assert property (p_fault_sticky) // R6
        else $error("fault flag dropped without clear");

    property p_fault_hi_read;
        ar_hs && rd_hit && rd_idx == IDX_FLT_HI ##1
            s_axi_rvalid |-> s_axi_rdata[31:5] == '0 &&
            s_axi_rdata[4:0] == $past(fault.hi);
    endproperty
    a_fault_hi_read: assert property (p_fault_hi_read) // R8
        else $error("fault high read mismatch");

    property p_fault_needs_loss;
        ##1 (~$past(fault) & fault & ~$past(fault_set)) == '0;
    endproperty
    a_fault_needs_loss: assert property (p_fault_needs_loss) // R9
        else $error("fault flag set without loss");

    property p_zero_write_keeps;
        wr_fire && wr_idx == IDX_FLT_LO && wdata_r[7:0] == 8'h00 |=>
            (fault.lo & $past(fault.lo)) == $past(fault.lo);
    endproperty
    a_zero_write_keeps: assert property (p_zero_write_keeps) // R10
        else $error("zero write changed a fault flag");

    property p_set_beats_clear;
        (fault_set & fault_clr) != '0 |=>
            (fault & $past(fault_set)) == $past(fault_set);
    endproperty
    a_set_beats_clear: assert property (p_set_beats_clear) // R11
        else $error("clear won over simultaneous set");

    property p_write_resp;
        aw_held_r && w_held_r && !bvalid_r |=> s_axi_bvalid;
    endproperty
    a_write_resp: assert property (p_write_resp)
        else $error("write response missing");

    property p_irq_level;
        ##1 irq == |({$past(mask_hi_r), $past(mask_lo_r)} &
            $past(fault));
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt level mismatch");

    c_fault_cleared: cover property (
        fault.lo != '0 ##1 fault_clr.lo != '0 ##1 fault.lo == '0);
    c_set_clear_clash: cover property ((fault_set & fault_clr) != '0);
    c_irq_raised: cover property (!irq ##1 irq);
    c_bad_addr: cover property (
        s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule
`default_nettype wire

// ### rtl/rsr_w1c.sv
// Sticky flag bank, write-one-to-clear, set has priority
`default_nettype none
module rsr_w1c #(
    parameter int W = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    output logic [W-1:0] flags
);
    import rsr_pkg::*;
    logic [W-1:0] flags_r;
    logic [W-1:0] flags_nxt;

    always_comb begin
        flags_nxt = (flags_r & ~clr) | set;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_r <= '0;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    assign flags = flags_r;
endmodule
`default_nettype wire

// ### verification/test_rsr_top.sv
// Self-checking bench for the rail status register bank
`default_nettype none
module test_rsr_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rsr_pkg::*;

    localparam logic [11:0] A_PGL = {2'h0, IDX_PG_LO, 2'h0};
    localparam logic [11:0] A_FL = {2'h0, IDX_FLT_LO, 2'h0};
    localparam logic [11:0] A_ML = {2'h0, IDX_MASK_LO, 2'h0};
    localparam int CYC_LIMIT = 20000;

    logic aclk;
    logic aresetn;
    rsr_pg_t rails;
    logic [11:0] s_axi_awaddr;
    logic [11:0] s_axi_araddr;
    logic [31:0] s_axi_wdata;
    logic [31:0] s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp;
    logic [1:0] s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, irq;
    logic [13:0] exp_pg;
    logic [15:0] exp_f;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;

    rsr_top u_dut (
        .aclk(aclk),
        .aresetn(aresetn),
        .rail_in_regulation(rails),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .irq(irq)
    );

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    task automatic close_out();
        if (num_errors == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge aclk) begin
        cycles++;
        if (cycles > CYC_LIMIT) begin
            num_errors++;
            close_out();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // Both channels offered together, each dropped when taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
            input logic [3:0] s, input logic [1:0] er);
        logic aw_ok, w_ok, b_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        b_ok = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b_ok) begin
            @(posedge aclk);
            if (!aw_ok && s_axi_awready === 1'b1) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready === 1'b1) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid === 1'b1) begin
                b_ok = 1'b1;
                s_axi_bready <= 1'b0;
                check({30'h0, s_axi_bresp}, {30'h0, er});
            end
        end
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] ed,
            input logic [1:0] er);
        logic r_ok;
        r_ok = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!r_ok) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready === 1'b1) begin
                s_axi_arvalid <= 1'b0;
            end
            if (s_axi_rvalid === 1'b1) begin
                r_ok = 1'b1;
                s_axi_rready <= 1'b0;
                check(s_axi_rdata, ed);
                check({30'h0, s_axi_rresp}, {30'h0, er});
            end
        end
    endtask

    // Register pair: low byte at a, high byte at the next word
    task automatic wr2(input logic [11:0] a, input logic [15:0] v);
        wr(a, {24'h0, v[7:0]}, 4'hf, RESP_OKAY);
        wr(a + 12'h4, {24'h0, v[15:8]}, 4'hf, RESP_OKAY);
    endtask

    task automatic rd2(input logic [11:0] a, input logic [15:0] v);
        rd(a, {24'h0, v[7:0]}, RESP_OKAY);
        rd(a + 12'h4, {24'h0, v[15:8]}, RESP_OKAY);
    endtask

    initial begin
        aresetn = 1'b0;
        rails = '0;
        s_axi_awaddr = '0;
        s_axi_araddr = '0;
        s_axi_wdata = '0;
        s_axi_wstrb = '0;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd2(A_PGL, 16'h0000);
        rd2(A_FL, 16'h0000);
        rd2(A_ML, 16'h0000);
        rails <= 14'h3fff;
        wait_cyc(4);
        rd2(A_PGL, 16'h3fff);
        wr2(A_PGL, 16'h0000);
        rd2(A_PGL, 16'h3fff);
        rd2(A_FL, 16'h0000);
        // One rail at a time drops out of regulation
        for (int i = 0; i < PG_W; i++) begin
            exp_pg = 14'h3fff & ~(14'h1 << i);
            exp_f = (i < FLT_W) ? (16'h1 << i) : 16'h0;
            rails <= exp_pg;
            wait_cyc(6);
            rd2(A_PGL, {2'h0, exp_pg});
            rd2(A_FL, exp_f);
            rails <= 14'h3fff;
            wait_cyc(6);
            wr2(A_FL, ~exp_f);
            rd2(A_FL, exp_f);
            wr2(A_FL, exp_f);
            rd2(A_FL, 16'h0000);
        end
        wr2(A_ML, 16'hffff);
        rd2(A_ML, 16'h1fff);
        wr2(A_ML, 16'h0001);
        rails <= 14'h3ffd;
        wait_cyc(6);
        check({31'h0, irq}, 32'h0);
        rails <= 14'h3ffc;
        wait_cyc(6);
        check({31'h0, irq}, 32'h1);
        wr(A_FL, 32'h0, 4'hf, RESP_OKAY);
        rd(A_FL, 32'h3, RESP_OKAY);
        rails <= 14'h3fff;
        wr2(A_FL, 16'h0002);
        wait_cyc(2);
        check({31'h0, irq}, 32'h1);
        wr(A_FL, 32'h1, 4'h0, RESP_OKAY);
        wait_cyc(2);
        check({31'h0, irq}, 32'h1);
        wr2(A_ML, 16'h0000);
        wait_cyc(2);
        check({31'h0, irq}, 32'h0);
        wr2(A_ML, 16'h0001);
        wait_cyc(2);
        check({31'h0, irq}, 32'h1);
        // Reset again with a flag pending
        aresetn <= 1'b0;
        wait_cyc(3);
        aresetn <= 1'b1;
        check({31'h0, irq}, 32'h0);
        rd2(A_FL, 16'h0000);
        rd2(A_ML, 16'h0000);
        rd2(A_PGL, 16'h3fff);
        // Rail chatters while the host clears its flag
        fork
            repeat (20) begin
                @(posedge aclk);
                rails.lo[0] <= ~rails.lo[0];
            end
            begin
                wr(A_FL, 32'h1, 4'hf, RESP_OKAY);
                wr(A_FL, 32'h1, 4'hf, RESP_OKAY);
            end
        join
        wait_cyc(6);
        rd(A_FL, 32'h1, RESP_OKAY);
        wr(12'h2d0, 32'hff, 4'hf, RESP_SLVERR);
        rd(12'h2d0, 32'h0, RESP_SLVERR);
        rd(12'h2c1, 32'h0, RESP_SLVERR);
        close_out();
    end
endmodule
`default_nettype wire
